// ### nvp_access_port.sv
// Processor access port to a 512-byte nonvolatile data array.
// Assumes a simple I/O-space port on the CPU clock: one-cycle write and
// read strobes, read data sampled the cycle after the read strobe.
`include "nvp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

// Contract
// - 512 independently accessible nonvolatile bytes.
// - 9-bit linear address over two registers.
// - Address bits 15..9 read as zero.
// - Write stores data byte at address.
// - Read loads addressed byte into data.
// - Control bits 7..4 read as zero.
// - Bit 3 enables interrupt, gated by global.
// - Ready interrupt is level while strobe clear.
// - Strobe within four cycles of arm writes.
// - Strobe without arm is ignored.
// - Arm self-clears four cycles after set.
// - Read halts processor four cycles.
// - Write halts processor two cycles.
// - Self-timed write, completion visible to software.
// - Registers reachable in I/O space.
// - Bit 1 write strobe, set during write.
// - Strobe clears after 8448 oscillator ticks.
// - Bit 0 read strobe, data next instruction.
// - During write ignore reads, freeze address.
module nvp_access_port #(
  // Write period in oscillator ticks; benches shorten it to keep runs short.
  parameter int unsigned WRITE_TICKS = `NVP_WRITE_OSC_TICKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Processor I/O port
  input wire logic [1:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Processor status and control
  input wire logic global_irq_enable_i,
  output logic cpu_halt_o,
  output logic ready_irq_o
);

  logic [7:0] mem [0:`NVP_DEPTH-1];

  logic [`NVP_ADDR_W-1:0] addr_reg;
  logic [`NVP_ADDR_W-1:0] addr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  nvp_pkg::nvp_ctrl_t ctrl_reg;
  nvp_pkg::nvp_ctrl_t ctrl_next;
  logic [2:0] arm_cnt_reg;
  logic [2:0] arm_cnt_next;
  logic [2:0] halt_reg;
  logic [2:0] halt_next;
  logic halt_on_reg;
  logic halt_on_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic irq_reg;
  logic irq_next;
  nvp_pkg::nvp_wreq_t wreq_reg;
  nvp_pkg::nvp_wreq_t wreq_next;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  logic ctl_wr;
  logic [7:0] ctrl_rd;

  assign ctl_wr = io_wr_i && (io_addr_i == `NVP_OFS_CONTROL);
  assign ctrl_rd = {4'h0, ctrl_reg.ready_irq_enable, ctrl_reg.write_arm,
                    ctrl_reg.write_strobe, ctrl_reg.read_strobe};

  always_comb
  begin
    addr_next = addr_reg;
    data_next = data_reg;
    ctrl_next = ctrl_reg;
    arm_cnt_next = arm_cnt_reg;
    halt_next = (halt_reg != 3'h0) ? halt_reg - 3'h1 : 3'h0;
    wreq_next = wreq_reg;
    timer_start = 1'b0;
    ctrl_next.read_strobe = 1'b0;
    // The arm window counts down; it is cleared when it runs out.
    if (arm_cnt_reg != 3'h0)
    begin
      arm_cnt_next = arm_cnt_reg - 3'h1;
      if (arm_cnt_reg == 3'h1)
      begin
        ctrl_next.write_arm = 1'b0;
      end
    end
    if (timer_done)
    begin
      ctrl_next.write_strobe = 1'b0;
    end
    // Address stays frozen while the array is being programmed.
    if (io_wr_i && !ctrl_reg.write_strobe)
    begin
      if (io_addr_i == `NVP_OFS_ADDR_HIGH)
      begin
        addr_next[8] = io_wdata_i[0];
      end
      if (io_addr_i == `NVP_OFS_ADDR_LOW)
      begin
        addr_next[7:0] = io_wdata_i;
      end
    end
    if (io_wr_i && io_addr_i == `NVP_OFS_DATA)
    begin
      data_next = io_wdata_i;
    end
    if (ctl_wr)
    begin
      ctrl_next.ready_irq_enable = io_wdata_i[`NVP_BIT_READY_IRQ_EN];
      if (io_wdata_i[`NVP_BIT_WRITE_ARM])
      begin
        ctrl_next.write_arm = 1'b1;
        arm_cnt_next = `NVP_ARM_CYCLES;
      end
      // A write strobe without a live arm, or during a write, does nothing.
      if (io_wdata_i[`NVP_BIT_WRITE_STROBE] && ctrl_reg.write_arm &&
          !ctrl_reg.write_strobe && !timer_busy)
      begin
        ctrl_next.write_strobe = 1'b1;
        timer_start = 1'b1;
        wreq_next.addr = addr_reg;
        wreq_next.data = data_reg;
        halt_next = `NVP_WRITE_HALT;
      end
      else if (io_wdata_i[`NVP_BIT_READ_STROBE] && !ctrl_reg.write_strobe)
      begin
        ctrl_next.read_strobe = 1'b1;
        data_next = mem[addr_reg];
        halt_next = `NVP_READ_HALT;
      end
    end
    rdata_next = rdata_reg;
    if (io_rd_i)
    begin
      case (io_addr_i)
        `NVP_OFS_ADDR_HIGH: rdata_next = {7'h00, addr_reg[8]};
        `NVP_OFS_ADDR_LOW: rdata_next = addr_reg[7:0];
        `NVP_OFS_DATA: rdata_next = data_reg;
        default: rdata_next = ctrl_rd;
      endcase
    end
    irq_next = ctrl_next.ready_irq_enable && global_irq_enable_i &&
               !ctrl_next.write_strobe;
    halt_on_next = (halt_next != 3'h0);
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      addr_reg <= 9'h000;
      data_reg <= 8'h00;
      ctrl_reg <= '0;
      arm_cnt_reg <= 3'h0;
      halt_reg <= 3'h0;
      halt_on_reg <= 1'b0;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
      wreq_reg <= '0;
    end
    else
    begin
      addr_reg <= addr_next;
      data_reg <= data_next;
      ctrl_reg <= ctrl_next;
      arm_cnt_reg <= arm_cnt_next;
      halt_reg <= halt_next;
      halt_on_reg <= halt_on_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      wreq_reg <= wreq_next;
    end
  end

  // The array commits at the end of the timed period, so a reset mid-write
  // leaves the old byte intact.
  always_ff @(posedge mclk_i)
  begin
    if (timer_done)
    begin
      mem[wreq_reg.addr] <= wreq_reg.data;
    end
  end

  nvp_write_timer #(.TICKS(WRITE_TICKS)) u_timer (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .start_i(timer_start),
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  assign io_rdata_o = rdata_reg;
  assign cpu_halt_o = halt_on_reg;
  assign ready_irq_o = irq_reg;

endmodule

`default_nettype wire

// ### nvp_defs.svh
// Constants for the nonvolatile data access port: offsets, fields, timing.
// Assumes inclusion by bare name from files of the same folder.
`ifndef NVP_DEFS_SVH
`define NVP_DEFS_SVH

// I/O-space register offsets (byte index on the processor I/O port).
`define NVP_OFS_ADDR_HIGH 2'h0
`define NVP_OFS_ADDR_LOW 2'h1
`define NVP_OFS_DATA 2'h2
`define NVP_OFS_CONTROL 2'h3

// Control register bit positions.
`define NVP_BIT_READ_STROBE 0
`define NVP_BIT_WRITE_STROBE 1
`define NVP_BIT_WRITE_ARM 2
`define NVP_BIT_READY_IRQ_EN 3

// Array geometry.
`define NVP_ADDR_W 9
`define NVP_DEPTH 512

// Timing.
`define NVP_ARM_CYCLES 3'h4
`define NVP_READ_HALT 3'h4
`define NVP_WRITE_HALT 3'h2
`define NVP_WRITE_OSC_TICKS 8448
`define NVP_OSC_FREQ_HZ 1000000
`define NVP_CLK_FREQ_HZ 50000000
`define NVP_OSC_DIV (`NVP_CLK_FREQ_HZ / `NVP_OSC_FREQ_HZ)

`endif

// ### nvp_pkg.sv
// Types shared by the nonvolatile data access port.
// Assumes nvp_defs.svh sits in the same folder.
`include "nvp_defs.svh"

package nvp_pkg;

  typedef struct packed {
    logic ready_irq_enable;
    logic write_arm;
    logic write_strobe;
    logic read_strobe;
  } nvp_ctrl_t;

  typedef struct packed {
    logic [`NVP_ADDR_W-1:0] addr;
    logic [7:0] data;
  } nvp_wreq_t;

endpackage

// ### nvp_write_timer.sv
// Self-timed write period: a 1 MHz tick from a divider of the CPU clock,
// counted to the programming time. Assumes start only while not busy.
`include "nvp_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module nvp_write_timer #(
  parameter int unsigned TICKS = `NVP_WRITE_OSC_TICKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  localparam int unsigned DIV = `NVP_OSC_DIV;

  logic [5:0] div_reg;
  logic [5:0] div_next;
  logic [13:0] tick_reg;
  logic [13:0] tick_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    div_next = div_reg;
    tick_next = tick_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start_i && !busy_reg)
    begin
      busy_next = 1'b1;
      div_next = 6'h00;
      tick_next = 14'h0000;
    end
    else if (busy_reg)
    begin
      if (div_reg == 6'(DIV - 1))
      begin
        div_next = 6'h00;
        if (tick_reg == 14'(TICKS - 1))
        begin
          busy_next = 1'b0;
          done_next = 1'b1;
        end
        else
        begin
          tick_next = tick_reg + 14'h0001;
        end
      end
      else
      begin
        div_next = div_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_reg <= 6'h00;
      tick_reg <= 14'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;

endmodule

`default_nettype wire

// ### nvp_access_port_asserts.sv
// Pin-level checks on the nonvolatile data access port.
// Assumes a bind to nvp_access_port; offsets come from nvp_defs.svh.
`include "nvp_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module nvp_access_port_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Processor port
  input wire logic [1:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic global_irq_enable_i,
  input wire logic cpu_halt_o,
  input wire logic ready_irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  irq_gate_a: assert property (
    !global_irq_enable_i |=> !ready_irq_o)
    else $error("ready irq without global enable");
  halt_cause_a: assert property (
    $rose(cpu_halt_o) |-> $past(io_wr_i && io_addr_i == `NVP_OFS_CONTROL))
    else $error("halt without control write");
  halt_min_a: assert property (
    $rose(cpu_halt_o) |-> cpu_halt_o[*2])
    else $error("halt too short");
  halt_max_a: assert property (
    cpu_halt_o[*4] |=> !cpu_halt_o)
    else $error("halt too long");
  rdata_hold_a: assert property (
    !io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved without read");
  ctrl_rsvd_a: assert property (
    io_rd_i && io_addr_i == `NVP_OFS_CONTROL |=> io_rdata_o[7:4] == 4'h0)
    else $error("control reserved bits set");
  addr_rsvd_a: assert property (
    io_rd_i && io_addr_i == `NVP_OFS_ADDR_HIGH |=> io_rdata_o[7:1] == 7'h00)
    else $error("address high reserved bits set");
  data_back_a: assert property (
    io_wr_i && io_addr_i == `NVP_OFS_DATA ##1 !io_wr_i ##1
    io_rd_i && io_addr_i == `NVP_OFS_DATA |=>
    io_rdata_o == $past(io_wdata_i, 3))
    else $error("data register readback wrong");
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the nonvolatile data access port.
// Assumes the design files and nvp_defs.svh sit in the same folder.
`include "nvp_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] io_addr_i = 2'h0;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o;
  logic global_irq_enable_i = 1'b0;
  logic cpu_halt_o;
  logic ready_irq_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0 = 0;
  // A short write period keeps the run well inside its cycle budget.
  localparam int WR_TICKS = 4;
  localparam int WR_CYC = WR_TICKS * `NVP_OSC_DIV;
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc++;
  nvp_access_port #(.WRITE_TICKS(WR_TICKS)) i_dut (.mclk_i, .reset_n_i,
    .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
    .global_irq_enable_i,
    .cpu_halt_o, .ready_irq_o);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_cyc(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %0t cycles got %0d exp %0d", $time, got, exp);
    end
  endtask
  // Callers stand at a falling edge; each task returns at one. Each idles
  // one cycle first, so back-to-back calls never re-raise a strobe in the
  // step that dropped it.
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(negedge mclk_i);
    io_wr_i = 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] exp);
    @(negedge mclk_i);
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(negedge mclk_i);
    io_rd_i = 1'b0;
    chk(io_rdata_o, exp);
  endtask
  // Counts halt cycles in a fixed window, so a stuck halt cannot hang us.
  task halt(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    repeat (8)
    begin
      if (cpu_halt_o === 1'b1)
        n++;
      @(negedge mclk_i);
    end
    chk(n, exp);
  endtask
  task close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge mclk_i);
    reset_n_i = 1'b1;
    chk({7'h00, ready_irq_o}, 8'h00);
    rd(`NVP_OFS_CONTROL, 8'h00);
    wr(`NVP_OFS_ADDR_HIGH, 8'hFF);
    rd(`NVP_OFS_ADDR_HIGH, 8'h01);
    wr(`NVP_OFS_ADDR_LOW, 8'hA5);
    rd(`NVP_OFS_ADDR_LOW, 8'hA5);
    wr(`NVP_OFS_DATA, 8'h3C);
    rd(`NVP_OFS_DATA, 8'h3C);
    wr(`NVP_OFS_CONTROL, 8'h01);
    halt(8'h04);
    rd(`NVP_OFS_CONTROL, 8'h00);
    wr(`NVP_OFS_CONTROL, 8'h02);
    halt(8'h00);
    rd(`NVP_OFS_CONTROL, 8'h00);
    wr(`NVP_OFS_CONTROL, 8'h04);
    rd(`NVP_OFS_CONTROL, 8'h04);
    rd(`NVP_OFS_CONTROL, 8'h04);
    rd(`NVP_OFS_CONTROL, 8'h00);
    global_irq_enable_i = 1'b1;
    wr(`NVP_OFS_CONTROL, 8'h08);
    @(negedge mclk_i);
    chk({7'h00, ready_irq_o}, 8'h01);
    global_irq_enable_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    chk({7'h00, ready_irq_o}, 8'h00);
    global_irq_enable_i = 1'b1;
    wr(`NVP_OFS_DATA, 8'h5A);
    wr(`NVP_OFS_CONTROL, 8'h0C);
    wr(`NVP_OFS_CONTROL, 8'h0A);
    t0 = cyc;
    halt(8'h02);
    rd(`NVP_OFS_CONTROL, 8'h0A);
    chk({7'h00, ready_irq_o}, 8'h00);
    wr(`NVP_OFS_ADDR_LOW, 8'h11);
    rd(`NVP_OFS_ADDR_LOW, 8'hA5);
    wr(`NVP_OFS_DATA, 8'h77);
    wr(`NVP_OFS_CONTROL, 8'h0B);
    halt(8'h00);
    // The strobe drops, and the irq rises, one cycle after the period ends.
    for (int i = 0; i < 2 * WR_CYC && ready_irq_o !== 1'b1; i++)
      @(negedge mclk_i);
    chk_cyc(32'(cyc - t0), 32'(WR_CYC + 1));
    rd(`NVP_OFS_CONTROL, 8'h08);
    chk({7'h00, ready_irq_o}, 8'h01);
    wr(`NVP_OFS_CONTROL, 8'h01);
    chk({7'h00, ready_irq_o}, 8'h00);
    rd(`NVP_OFS_DATA, 8'h5A);
    close_out;
  end
endmodule
bind nvp_access_port nvp_access_port_asserts i_chk (.mclk_i, .reset_n_i,
  .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
  .global_irq_enable_i, .cpu_halt_o, .ready_irq_o);
`default_nettype wire
